// *** common/supervisor_pkg.sv ***
// constants shared by the supervisor and the processor-side reset end
package supervisor_pkg;
    localparam int unsigned CLK_MHZ          = 100;
    // hold period options, minimum microseconds
    localparam int unsigned HOLD_1MS_US      = 1000;
    localparam int unsigned HOLD_20MS_US     = 20000;
    localparam int unsigned HOLD_140MS_US    = 140000;
    localparam int unsigned HOLD_1120MS_US   = 1120000;
    // watchdog period options, nominal microseconds
    localparam int unsigned WD_6P3MS_US      = 6300;
    localparam int unsigned WD_102MS_US      = 102000;
    localparam int unsigned WD_1P6S_US       = 1600000;
    localparam int unsigned WD_25P6S_US      = 25600000;
    // manual reset filter: glitches of 100 ns rejected, 1 us pulses taken
    localparam int unsigned MR_GLITCH_NS     = 100;
    localparam int unsigned MR_FILTER_NS     = 500;
    localparam int unsigned MR_FILTER_CYC    = (MR_FILTER_NS * CLK_MHZ) / 1000;
    // least low time on the shared line to set the transition flag
    localparam int unsigned LINE_SETUP_NS    = 400;
    localparam int unsigned LINE_SETUP_CYC   = (LINE_SETUP_NS * CLK_MHZ + 999) / 1000;
    // active pull-up one-shot
    localparam int unsigned ONESHOT_NS       = 2000;
    localparam int unsigned ONESHOT_CYC      = (ONESHOT_NS * CLK_MHZ) / 1000;
    // processor side: drive four clocks, sample two later
    localparam int unsigned HOST_DRIVE_CYC   = 4;
    localparam int unsigned HOST_SAMPLE_CYC  = 2;
    // option selectors
    localparam logic [1:0]  OPT_A            = 2'h0;
    localparam logic [1:0]  OPT_B            = 2'h1;
    localparam logic [1:0]  OPT_C            = 2'h2;
    localparam logic [1:0]  OPT_D            = 2'h3;
    // output stage kinds
    localparam logic [1:0]  OUT_PUSH_PULL    = 2'h0;
    localparam logic [1:0]  OUT_OPEN_DRAIN   = 2'h1;
    localparam logic [1:0]  OUT_BIDIR        = 2'h2;

    function automatic int unsigned hold_us(input logic [1:0] sel);
        unique case (sel)
            OPT_A: return HOLD_1MS_US;
            OPT_B: return HOLD_20MS_US;
            OPT_C: return HOLD_140MS_US;
            default: return HOLD_1120MS_US;
        endcase
    endfunction

    function automatic int unsigned wd_us(input logic [1:0] sel);
        unique case (sel)
            OPT_A: return WD_6P3MS_US;
            OPT_B: return WD_102MS_US;
            OPT_C: return WD_1P6S_US;
            default: return WD_25P6S_US;
        endcase
    endfunction
endpackage

// *** common/reset_line_if.sv ***
// shared reset line between supervisor and processor
interface reset_line_if;
    logic rst_n_out;      // supervisor drives its low/high level
    logic rst_n_oe;       // supervisor drives the line
    logic pullup_on;      // passive pull-up connected
    logic active_pullup;  // fast pull-up on
    logic rst_high;       // active-high inverse output
    logic host_oe;        // processor pulls line low
    logic kick;           // watchdog kick level from processor
    logic kick_oe;        // processor drives the kick pin
    logic line_level;     // resolved line above enable level
    logic line_full;      // resolved line above 0.85 of supply

    modport supervisor (
        output rst_n_out, rst_n_oe, pullup_on, active_pullup, rst_high,
        input  host_oe, kick, kick_oe, line_level, line_full
    );
    modport processor (
        input  rst_n_out, rst_n_oe, rst_high, line_level, line_full,
        output host_oe, kick, kick_oe
    );
endinterface

// *** rtl/reset_supervisor_watchdog.sv ***
// supervisor end: reset generation, watchdog, shared line control
// ************************************************************
// ************************************************************
module reset_supervisor_watchdog #(
    parameter logic [1:0]  HOLD_SEL  = supervisor_pkg::OPT_C,
    parameter logic [1:0]  WD_SEL    = supervisor_pkg::OPT_A,
    parameter logic [1:0]  OUT_KIND  = supervisor_pkg::OUT_BIDIR,
    parameter int unsigned HOLD_CYC  = supervisor_pkg::hold_us(HOLD_SEL) * supervisor_pkg::CLK_MHZ,
    parameter int unsigned WD_CYC    = supervisor_pkg::wd_us(WD_SEL) * supervisor_pkg::CLK_MHZ
) (
    // clock and reset
    input  wire logic  clk_sys_i,
    input  wire logic  nrst_i,
    input  wire logic  clk_en_i,
    // monitored conditions
    input  wire logic  supply_low_i,
    input  wire logic  manual_reset_n_i,
    // status
    output logic       reset_asserted_o,
    // shared line
    reset_line_if.supervisor line
);
    // ************************************************************
    // parameter check
    // ************************************************************
    if (HOLD_CYC < 1 || WD_CYC < 8 || OUT_KIND == 2'h3) begin : g_bad_params
        $error("reset_supervisor_watchdog: bad parameters");
    end

    // counter width covers the longest watchdog period
    localparam int unsigned W     = 32;
    // stage decode shared by cause, hold and pull-up logic
    localparam logic        BIDIR = (OUT_KIND == supervisor_pkg::OUT_BIDIR);

    // ************************************************************
    // manual reset filter
    // ************************************************************
    logic [7:0] mr_cnt_reg, mr_cnt_next;
    logic       mr_low_reg, mr_low_next;
    always_comb begin
        mr_cnt_next = mr_cnt_reg;
        mr_low_next = mr_low_reg;
        if (manual_reset_n_i == !mr_low_reg) begin
            mr_cnt_next = 8'h00;
        end else if (mr_cnt_reg >= 8'(supervisor_pkg::MR_FILTER_CYC - 1)) begin
            mr_low_next = !manual_reset_n_i;
            mr_cnt_next = 8'h00;
        end else begin
            mr_cnt_next = mr_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mr_cnt_reg <= '0;
            mr_low_reg <= 1'b0;
        end else if (clk_en_i) begin
            mr_cnt_reg <= mr_cnt_next;
            mr_low_reg <= mr_low_next;
        end
    end

    // ************************************************************
    // watchdog
    // ************************************************************
    logic [W-1:0] wd_cnt_reg, wd_cnt_next;
    logic         kick_prev_reg, kick_prev_next;
    logic         wd_trip;
    logic         rst_reg, rst_next;
    always_comb begin
        kick_prev_next = line.kick;
        wd_cnt_next    = wd_cnt_reg + W'(1);
        wd_trip        = 1'b0;
        if (rst_reg || (line.kick_oe && line.kick != kick_prev_reg)) begin
            wd_cnt_next = '0;
        end else if (!line.kick_oe && wd_cnt_reg >= W'((WD_CYC / 8) * 7 - 1)) begin
            wd_cnt_next = '0;
        end else if (wd_cnt_reg >= W'(WD_CYC - 1)) begin
            wd_trip     = 1'b1;
            wd_cnt_next = '0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wd_cnt_reg    <= '0;
            kick_prev_reg <= 1'b0;
        end else if (clk_en_i) begin
            wd_cnt_reg    <= wd_cnt_next;
            kick_prev_reg <= kick_prev_next;
        end
    end

    // ************************************************************
    // reset hold
    // ************************************************************
    logic [W-1:0] hold_cnt_reg, hold_cnt_next;
    logic         cause;
    always_comb begin
        cause = supply_low_i || mr_low_reg || wd_trip
            || (BIDIR && !line.line_level && !rst_reg);
        rst_next      = rst_reg;
        hold_cnt_next = hold_cnt_reg;
        if (cause || (BIDIR && line.host_oe)) begin
            rst_next      = 1'b1;
            hold_cnt_next = '0;
        end else if (rst_reg) begin
            if (hold_cnt_reg >= W'(HOLD_CYC - 1)) begin
                rst_next      = 1'b0;
                hold_cnt_next = '0;
            end else begin
                hold_cnt_next = hold_cnt_reg + W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_reg      <= 1'b1;
            hold_cnt_reg <= '0;
        end else if (clk_en_i) begin
            rst_reg      <= rst_next;
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    // ************************************************************
    // transition flag and one-shot
    // ************************************************************
    logic        flag_reg, flag_next;
    logic [15:0] os_cnt_reg, os_cnt_next;
    logic        apu_reg, apu_next;
    always_comb begin
        flag_next   = flag_reg;
        apu_next    = 1'b0;
        os_cnt_next = os_cnt_reg;
        if (!line.line_level) begin
            flag_next   = 1'b1;
            os_cnt_next = '0;
        end else if (flag_reg) begin
            if (line.line_full || os_cnt_reg >= 16'(supervisor_pkg::ONESHOT_CYC - 1)) begin
                flag_next = 1'b0;
            end else begin
                apu_next    = BIDIR;
                os_cnt_next = os_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_reg   <= 1'b0;
            os_cnt_reg <= '0;
            apu_reg    <= 1'b0;
        end else if (clk_en_i) begin
            flag_reg   <= flag_next;
            os_cnt_reg <= os_cnt_next;
            apu_reg    <= apu_next;
        end
    end

    // ************************************************************
    // output stage
    // ************************************************************
    // status follows the hold register
    assign reset_asserted_o   = rst_reg;
    // low level while asserting
    assign line.rst_n_out     = !rst_reg;
    assign line.rst_high      = rst_reg;
    assign line.rst_n_oe      = (OUT_KIND == supervisor_pkg::OUT_PUSH_PULL) ? 1'b1 : rst_reg;
    assign line.pullup_on     = BIDIR && !rst_reg;
    assign line.active_pullup = apu_reg && !rst_reg;
endmodule // reset_supervisor_watchdog

// *** rtl/reset_processor_end.sv ***
// processor end: bidirectional reset handshake and watchdog kick
module reset_processor_end (
    // clock and reset
    input  wire logic  clk_sys_i,
    input  wire logic  nrst_i,
    input  wire logic  clk_en_i,
    // user side
    input  wire logic  self_reset_i,
    input  wire logic  kick_level_i,
    input  wire logic  kick_enable_i,
    output logic       busy_o,
    output logic       cause_valid_o,
    output logic       cause_self_o,
    // shared line
    reset_line_if.processor line
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_DRIVE = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_HIGH  = 4'b1000
    } pst_e;

    pst_e       st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic       valid_reg, valid_next;
    logic       self_reg, self_next;

    always_comb begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        valid_next = 1'b0;
        self_next  = self_reg;
        unique case (st_reg)
            ST_IDLE: begin
                cnt_next = '0;
                if (self_reset_i || !line.line_level)
                    st_next = ST_DRIVE;
            end
            // drive four cycles, beyond 40 ns holds via cause
            ST_DRIVE: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg >= 4'(supervisor_pkg::HOST_DRIVE_CYC - 1)) begin
                    st_next  = ST_WAIT;
                    cnt_next = '0;
                end
            end
            ST_WAIT: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg >= 4'(supervisor_pkg::HOST_SAMPLE_CYC - 1)) begin
                    self_next = line.line_full;
                    st_next   = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (line.line_full) begin
                    valid_next = 1'b1;
                    st_next    = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg    <= ST_IDLE;
            cnt_reg   <= '0;
            valid_reg <= 1'b0;
            self_reg  <= 1'b0;
        end else if (clk_en_i) begin
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            valid_reg <= valid_next;
            self_reg  <= self_next;
        end
    end

    assign line.host_oe   = (st_reg == ST_DRIVE);
    assign line.kick      = kick_level_i;
    assign line.kick_oe   = kick_enable_i;
    assign busy_o         = (st_reg != ST_IDLE);
    assign cause_valid_o  = valid_reg;
    assign cause_self_o   = self_reg;
endmodule // reset_processor_end

// *** verif/reset_line_asserts.sv ***
// concurrent checks on the shared reset line
module reset_line_asserts #(
    parameter int unsigned HOLD_CYC = 20
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic rst_n_out,
    input wire logic rst_n_oe,
    input wire logic pullup_on,
    input wire logic active_pullup,
    input wire logic rst_high,
    input wire logic host_oe,
    input wire logic line_level,
    input wire logic line_full
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned low_cnt_reg;
    int unsigned low_cnt_next;
    int unsigned fast_cnt_reg;
    int unsigned fast_cnt_next;

    always_comb begin
        low_cnt_next  = rst_n_out ? 0 : low_cnt_reg + 1;
        fast_cnt_next = active_pullup ? fast_cnt_reg + 1 : 0;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_cnt_reg  <= 0;
            fast_cnt_reg <= 0;
        end else begin
            low_cnt_reg  <= low_cnt_next;
            fast_cnt_reg <= fast_cnt_next;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    AST_INV_OUT: assert property (rst_high == !rst_n_out)
        else $error("high output not inverse of low output");
    AST_PULLUP_OFF: assert property (!rst_n_out |-> !pullup_on && !active_pullup)
        else $error("pull-up on while asserting reset");
    AST_HELD_HIGH: assert property (rst_n_out |-> pullup_on)
        else $error("line not held high while idle");
    AST_DRIVE_LOW: assert property (rst_n_oe == !rst_n_out)
        else $error("line driven while not asserting");
    AST_LINE_CAUSE: assert property (!line_level && rst_n_out |=> !rst_n_out)
        else $error("low line did not assert reset");
    AST_FAST_ON: assert property ($rose(line_level) && !line_full |=> active_pullup)
        else $error("fast pull-up not started");
    AST_FAST_OFF: assert property (active_pullup && line_full |=> !active_pullup)
        else $error("fast pull-up not stopped at full level");
    AST_ONESHOT: assert property (active_pullup |-> fast_cnt_reg < supervisor_pkg::ONESHOT_CYC)
        else $error("fast pull-up beyond one-shot");
    AST_HOST_PULSE: assert property ($rose(host_oe) |-> host_oe [*4] ##1 !host_oe [*2])
        else $error("processor pull not four cycles");
    AST_HOLD_LEN: assert property ($rose(rst_n_out) |-> low_cnt_reg >= HOLD_CYC - 1)
        else $error("reset released before hold period");
endmodule // reset_line_asserts

// *** verif/reset_supervisor_watchdog_tb.sv ***
// self-checking bench: supervisor and processor end joined by the reset line
module reset_supervisor_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HOLD = 50;
    localparam int unsigned WDC  = 80;
    logic        clk_sys_i  = 1'b0;
    logic        nrst_i     = 1'b0;
    logic        supply_low = 1'b0;
    logic        mr_n       = 1'b1;
    logic        self_rst   = 1'b0;
    logic        kick       = 1'b0;
    logic        kick_en    = 1'b0;
    logic        ext_low    = 1'b0;
    logic        slow_line  = 1'b0;
    logic        busy;
    logic        rst_asserted;
    logic        cause_valid;
    logic        cause_self;
    logic [31:0] rng        = 32'h0001_04c3;
    int          n_fail     = 0;
    int          n_checks   = 0;
    int          cycles     = 0;
    logic        exp_q[$];

    reset_line_if bus ();
    // line resolved from every party that may pull it low
    assign bus.line_level = !((bus.rst_n_oe && !bus.rst_n_out) || bus.host_oe || ext_low);
    // slow line models a heavily loaded line that never reaches the full level
    always_ff @(posedge clk_sys_i) bus.line_full <= bus.line_level && !slow_line;

    reset_supervisor_watchdog #(.HOLD_CYC(HOLD), .WD_CYC(WDC)) reset_supervisor_watchdog_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .supply_low_i(supply_low),
        .manual_reset_n_i(mr_n), .reset_asserted_o(rst_asserted), .line(bus));
    reset_processor_end reset_processor_end_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .self_reset_i(self_rst),
        .kick_level_i(kick), .kick_enable_i(kick_en), .busy_o(busy), .cause_valid_o(cause_valid),
        .cause_self_o(cause_self), .line(bus));
    reset_line_asserts #(.HOLD_CYC(HOLD)) reset_line_asserts_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rst_n_out(bus.rst_n_out), .rst_n_oe(bus.rst_n_oe),
        .pullup_on(bus.pullup_on), .active_pullup(bus.active_pullup), .rst_high(bus.rst_high),
        .host_oe(bus.host_oe), .line_level(bus.line_level), .line_full(bus.line_full));

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic wait_level(input logic v, input int lim, output int took);
        took = 0;
        while (rst_asserted !== v && took < lim) begin
            cyc(1);
            took++;
        end
    endtask

    // every reset is seen by the processor as an outside one
    task automatic timed_release(input string what, input int extra);
        int t;
        exp_q.push_back(1'b0);
        wait_level(1'b0, HOLD + 60, t);
        check(what, 1'b1, t >= HOLD - 1 && t <= HOLD + extra);
        cyc(10);
        $display("test %s done", what);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // cause notes taken in order as the processor reports them
    always @(negedge clk_sys_i) begin
        if (cause_valid === 1'b1) begin
            if (exp_q.size() == 0) check("cause extra", 1'b0, 1'b1);
            else check("cause self", exp_q.pop_front(), cause_self);
        end
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        int t;
        int n;
        cyc(4);
        nrst_i = 1'b1;
        timed_release("power up", 6);
        supply_low = 1'b1;
        cyc(2);
        check("supply reset", 1'b1, rst_asserted);
        cyc(30);
        supply_low = 1'b0;
        timed_release("supply hold", 3);
        mr_n = 1'b0;
        cyc(10);
        mr_n = 1'b1;
        cyc(60);
        check("mr glitch", 1'b0, rst_asserted);
        $display("test mr glitch done");
        mr_n = 1'b0;
        wait_level(1'b1, 80, t);
        check("mr delay", 1'b1, t >= 49 && t <= 53);
        cyc(100 - t);
        mr_n = 1'b1;
        timed_release("mr hold", 55);
        kick_en = 1'b1;
        cyc(1);
        kick = ~kick;
        for (int i = 0; i < 12; i++) begin
            rng = xs(rng);
            cyc(int'(rng[5:0]) + 1);
            kick = ~kick;
            check("kicked", 1'b0, rst_asserted);
        end
        wait_level(1'b1, WDC + 10, t);
        check("wd trip", 1'b1, t >= WDC - 2 && t <= WDC + 2);
        timed_release("wd hold", 6);
        wait_level(1'b1, WDC + 10, t);
        check("wd restart", 1'b1, t >= WDC - 12 && t <= WDC + 2);
        timed_release("wd hold again", 6);
        kick_en = 1'b0;
        for (int i = 0; i < 6; i++) begin
            cyc(WDC / 2);
            check("open kick", 1'b0, rst_asserted);
        end
        $display("test open kick done");
        self_rst = 1'b1;
        cyc(1);
        check("busy", 1'b1, busy);
        self_rst = 1'b0;
        wait_level(1'b1, 4, t);
        check("self pull", 1'b1, rst_asserted);
        timed_release("self hold", 8);
        // outside pull for the least setup time, hold counted from its start
        ext_low   = 1'b1;
        slow_line = 1'b1;
        exp_q.push_back(1'b0);
        cyc(int'(supervisor_pkg::LINE_SETUP_CYC));
        check("ext pull", 1'b1, rst_asserted);
        ext_low = 1'b0;
        wait_level(1'b0, HOLD + 60, t);
        t = t + int'(supervisor_pkg::LINE_SETUP_CYC);
        check("ext hold", 1'b1, t >= HOLD - 1 && t <= HOLD + 8);
        // line never reaches full level: one-shot must end the fast pull-up
        n = 0;
        for (int i = 0; i < 260; i++) begin
            cyc(1);
            if (bus.active_pullup === 1'b1) n++;
        end
        check("one-shot", 1'b1, n >= int'(supervisor_pkg::ONESHOT_CYC) - 2 && n <= int'(supervisor_pkg::ONESHOT_CYC));
        slow_line = 1'b0;
        cyc(10);
        $display("test ext hold done");
        cyc(20);
        check("cause queue", 1'b1, exp_q.size() == 0);
        final_report();
    end
endmodule // reset_supervisor_watchdog_tb
